// ### tb/pprs_far_model.sv
`timescale 1ns/1ps
module pprs_far_model (
    input wire logic pclk,
    input wire logic hold,
    output logic [35:0] pin_in,
    output logic [35:0] port_latch_bit,
    output logic [36:0] periph_out
);
    integer seed = 32'h1ECCDDF5;
    initial begin
        pin_in = '0;
        port_latch_bit = '0;
        periph_out = '0;
    end
    // Pins, latches and peripherals move after each edge unless held
    always @(posedge pclk) begin
        if (!hold) begin
            pin_in <= 36'({$random(seed), $random(seed)});
            port_latch_bit <= 36'({$random(seed), $random(seed)});
            periph_out <= 37'({$random(seed), $random(seed)});
        end
    end
endmodule

// ### tb/pprs_route_tb.sv
`timescale 1ns/1ps
module pprs_route_tb;
    import pprs_pkg::*;
    logic pclk = 0, presetn = 0, por_n = 0, hold = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [35:0] pin_in, port_latch_bit, pin_out, ex;
    logic [36:0] periph_out;
    logic [7:0] periph_in;
    int n_fail = 0, comparisons = 0, k, r, code;
    int sel_in [8];
    int sel_out [36];
    integer seed = 32'h1ECCDDF5;
    always #5 pclk = ~pclk;
    pprs_route dut_u (.pclk(pclk), .presetn(presetn), .por_n(por_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in),
        .port_latch_bit(port_latch_bit), .periph_out(periph_out),
        .periph_in(periph_in), .pin_out(pin_out));
    pprs_far_model far_u (.pclk(pclk), .hold(hold), .pin_in(pin_in),
        .port_latch_bit(port_latch_bit), .periph_out(periph_out));
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        chk(36'(pslverr), 36'h0);
        penable <= 1'b0;
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask
    task automatic rdc(input logic [11:0] a, input int exp);
        apb(1'b0, a, 0);
        chk({4'h0, rd}, 36'(exp));
    endtask
    task automatic regs;
        for (k = 0; k < 8; k++) rdc(12'(IN_SEL_BASE + 4 * k), sel_in[k]);
        for (k = 0; k < 36; k++) rdc(12'(PIN_SEL_BASE + 4 * k), sel_out[k]);
    endtask
    task automatic route;
        hold <= 1'b1;
        idle(4);
        ex = '0;
        for (k = 0; k < 8; k++) ex[k] = pin_in[sel_in[k]];
        chk({28'h0, periph_in}, ex);
        for (k = 0; k < 36; k++) begin
            code = sel_out[k];
            ex[k] = code == 0 ? port_latch_bit[k] : periph_out[code - 1];
        end
        chk(pin_out, ex);
        hold <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("Mismatches %0d, comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic resets(input logic por);
        presetn <= 1'b0;
        por_n <= ~por;
        idle(3);
        presetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge pclk);
    endtask
    task automatic defaults;
        for (k = 0; k < 8; k++) sel_in[k] = IN_SEL_DEFAULTS[k * 6 +: 6];
        for (k = 0; k < 36; k++) sel_out[k] = 0;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        wrap_up;
    end
    initial begin
        defaults;
        resets(1'b1);
        regs;
        rdc(POR_FLAG_ADDR, 1);
        apb(1'b1, POR_FLAG_ADDR, 1);
        rdc(POR_FLAG_ADDR, 0);
        for (r = 0; r < 3; r++) begin
            for (k = 0; k < 8; k++) begin
                code = {$random(seed)} % (k == 0 ? 16 : 36);
                sel_in[k] = code;
                apb(1'b1, 12'(IN_SEL_BASE + 4 * k), $random(seed) & ~63 | code);
            end
            for (k = 0; k < 36; k++) begin
                sel_out[k] = (k + 36 * r) % 38;
                apb(1'b1, 12'(PIN_SEL_BASE + 4 * k), sel_out[k]);
            end
            regs;
            route;
        end
        apb(1'b1, LOCK_ADDR, 32'h55);
        apb(1'b1, LOCK_ADDR, 32'hAA);
        apb(1'b1, LOCK_ADDR, 1);
        apb(1'b1, IN_SEL_BASE, 3);
        apb(1'b1, PIN_SEL_BASE, 5);
        rdc(LOCK_ADDR, 1);
        regs;
        rdc(12'h300, 0);
        resets(1'b0);
        regs;
        rdc(POR_FLAG_ADDR, 0);
        rdc(LOCK_ADDR, 0);
        route;
        defaults;
        resets(1'b1);
        regs;
        rdc(POR_FLAG_ADDR, 1);
        route;
        wrap_up;
    end
endmodule

// ### verilog/pprs_pkg.sv
package pprs_pkg;
    // Pin, input and peripheral output counts, selector width
    localparam int NUM_PINS = 36;
    localparam int NUM_INPUTS = 8;
    localparam int NUM_PERIPH_OUT = 37;
    localparam int SEL_W = 6;
    // Register map, byte addresses
    localparam logic [11:0] IN_SEL_BASE = 12'h000;
    localparam logic [11:0] PIN_SEL_BASE = 12'h100;
    localparam logic [11:0] LOCK_ADDR = 12'h200;
    localparam logic [11:0] POR_FLAG_ADDR = 12'h204;
    // Lock register layout and unlock keys
    localparam int LOCK_BIT = 0;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
    // Output selector codes
    localparam logic [5:0] OUT_SEL_LATCH = 6'h00;
    localparam logic [5:0] OUT_SEL_MAX = 6'h25;
    // Default pin for each input selector, pins numbered RA0=0x00..RE3=0x23
    localparam logic [SEL_W*NUM_INPUTS-1:0] IN_SEL_DEFAULTS = {
        6'h16, 6'h17, 6'h0A, 6'h09, 6'h05, 6'h0C, 6'h0F, 6'h00};
    localparam logic [5:0] OUT_SEL_DEFAULT = 6'h00;
    typedef enum logic [1:0] {
        pprs_lk_idle,
        pprs_lk_key1,
        pprs_lk_armed
    } pprs_lock_state_t;
endpackage

// ### verilog/pprs_route.sv
// Operation
// - Power-on reset restores all selector defaults
// - Other resets keep all routing selections
// - Output code zero drives pin from latch
// - Output codes 0x01-0x25 pick one peripheral output, higher codes drive zero
// - Input selector bits 7-6 read zero
// - Input selector bits 5-0 pick pin
// - Input codes map RA0 upward through RE3
// - Each input resets to its own pin
// - One dedicated selector per peripheral input
// - Lock bit blocks selector writes
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module pprs_route #(
    parameter int N_PINS = pprs_pkg::NUM_PINS,
    parameter int N_INPUTS = pprs_pkg::NUM_INPUTS,
    parameter int N_POUT = pprs_pkg::NUM_PERIPH_OUT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_PINS-1:0] pin_in,
    input wire logic [N_PINS-1:0] port_latch_bit,
    input wire logic [N_POUT-1:0] periph_out,
    output logic [N_INPUTS-1:0] periph_in,
    output logic [N_PINS-1:0] pin_out
);
    import pprs_pkg::*;

    // Tables in the package fix the counts
    if (N_PINS != NUM_PINS || N_INPUTS != NUM_INPUTS ||
        N_POUT != NUM_PERIPH_OUT) begin : g_bad_counts
        $error("pprs_route: counts must match package tables");
    end

    logic [SEL_W-1:0] in_sel_reg [N_INPUTS];
    logic [SEL_W-1:0] pin_sel_reg [N_PINS];
    logic route_lock_flag_reg;
    logic por_seen_reg;
    pprs_lock_state_t lk_state_reg;
    logic [N_PINS-1:0] pin_s1_reg;
    logic [N_PINS-1:0] pin_s2_reg;
    logic [N_PINS-1:0] pin_out_reg;
    logic [N_INPUTS-1:0] periph_in_reg;
    logic [31:0] prdata_next;
    logic [31:0] prdata_reg;

    logic wr_acc;
    logic [11:0] in_off;
    logic [11:0] pin_off;
    logic in_hit;
    logic pin_hit;
    logic [5:0] idx_in;
    logic [5:0] idx_pin;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_acc = psel & penable & pwrite;
    assign in_off = paddr - IN_SEL_BASE;
    assign pin_off = paddr - PIN_SEL_BASE;
    assign in_hit = paddr[1:0] == 2'h0 && paddr >= IN_SEL_BASE &&
                    in_off < 12'(N_INPUTS * 4);
    assign pin_hit = paddr[1:0] == 2'h0 && paddr >= PIN_SEL_BASE &&
                     pin_off < 12'(N_PINS * 4);
    assign idx_in = in_off[7:2];
    assign idx_pin = pin_off[7:2];

    // Selector storage reset to defaults only by por_n, so presetn keeps routing
    generate
        for (genvar i = 0; i < N_INPUTS; i++) begin : g_in
            always_ff @(posedge pclk or negedge por_n) begin
                if (!por_n) begin
                    in_sel_reg[i] <= IN_SEL_DEFAULTS[i*SEL_W +: SEL_W];
                end else if (wr_acc && in_hit && idx_in == 6'(i) &&
                             !route_lock_flag_reg) begin
                    in_sel_reg[i] <= pwdata[SEL_W-1:0];
                end
            end
        end
        for (genvar p = 0; p < N_PINS; p++) begin : g_pin
            always_ff @(posedge pclk or negedge por_n) begin
                if (!por_n) begin
                    pin_sel_reg[p] <= OUT_SEL_DEFAULT;
                end else if (wr_acc && pin_hit && idx_pin == 6'(p) &&
                             !route_lock_flag_reg) begin
                    pin_sel_reg[p] <= pwdata[SEL_W-1:0];
                end
            end
        end
    endgenerate

    // Lock bit changes only on the write right after the two key writes, or on presetn
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_state_reg <= pprs_lk_idle;
            route_lock_flag_reg <= 1'b0;
        end else if (wr_acc && paddr == LOCK_ADDR) begin
            unique case (lk_state_reg)
                pprs_lk_idle: begin
                    lk_state_reg <= (pwdata[7:0] == UNLOCK_KEY1) ?
                                    pprs_lk_key1 : pprs_lk_idle;
                end
                pprs_lk_key1: begin
                    lk_state_reg <= (pwdata[7:0] == UNLOCK_KEY2) ?
                                    pprs_lk_armed : pprs_lk_idle;
                end
                pprs_lk_armed: begin
                    route_lock_flag_reg <= pwdata[LOCK_BIT];
                    lk_state_reg <= pprs_lk_idle;
                end
                default: begin
                    lk_state_reg <= pprs_lk_idle;
                end
            endcase
        end else if (wr_acc) begin
            lk_state_reg <= pprs_lk_idle;
        end
    end

    // Reports that a power-on reset occurred; write 1 to clear
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            por_seen_reg <= 1'b1;
        end else if (wr_acc && paddr == POR_FLAG_ADDR && pwdata[0]) begin
            por_seen_reg <= 1'b0;
        end
    end

    // Pin inputs are asynchronous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Registered routing muxes, updated from the stored selectors
    generate
        for (genvar i = 0; i < N_INPUTS; i++) begin : g_imux
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    periph_in_reg[i] <= 1'b0;
                end else if (in_sel_reg[i] < SEL_W'(N_PINS)) begin
                    periph_in_reg[i] <= pin_s2_reg[in_sel_reg[i]];
                end else begin
                    periph_in_reg[i] <= 1'b0;
                end
            end
        end
        for (genvar p = 0; p < N_PINS; p++) begin : g_omux
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_out_reg[p] <= 1'b0;
                end else if (pin_sel_reg[p] == OUT_SEL_LATCH) begin
                    pin_out_reg[p] <= port_latch_bit[p];
                end else if (pin_sel_reg[p] <= OUT_SEL_MAX) begin
                    pin_out_reg[p] <= periph_out[pin_sel_reg[p] - 6'h01];
                end else begin
                    pin_out_reg[p] <= 1'b0;
                end
            end
        end
    endgenerate

    assign periph_in = periph_in_reg;
    assign pin_out = pin_out_reg;

    always_comb begin
        prdata_next = '0;
        if (in_hit) begin
            prdata_next[SEL_W-1:0] = in_sel_reg[idx_in[2:0]];
        end else if (pin_hit) begin
            prdata_next[SEL_W-1:0] = pin_sel_reg[idx_pin];
        end else if (paddr == LOCK_ADDR) begin
            prdata_next[LOCK_BIT] = route_lock_flag_reg;
        end else if (paddr == POR_FLAG_ADDR) begin
            prdata_next[0] = por_seen_reg;
        end
    end
    // Read data captured in the setup cycle, stands through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (psel && !penable) begin
            prdata_reg <= prdata_next;
        end
    end
    assign prdata = prdata_reg;

    property p_lock_blocks;
        @(posedge pclk) disable iff (!presetn || !por_n)
        (route_lock_flag_reg && wr_acc && (in_hit || pin_hit)) |=>
            $stable(pin_sel_reg[0]) && $stable(in_sel_reg[0]);
    endproperty
    a_lock_blocks: assert property (p_lock_blocks)
        else $error("Selector changed while locked");

    property p_write_lands;
        @(posedge pclk) disable iff (!presetn || !por_n)
        (wr_acc && in_hit && idx_in == 6'h00 && !route_lock_flag_reg) |=>
            in_sel_reg[0] == $past(pwdata[5:0]);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("Input selector write lost");

    property p_latch_route;
        @(posedge pclk) disable iff (!presetn || !por_n)
        (presetn && pin_sel_reg[0] == OUT_SEL_LATCH) |=>
            pin_out[0] == $past(port_latch_bit[0]);
    endproperty
    a_latch_route: assert property (p_latch_route)
        else $error("Pin not driven from latch");

    property p_periph_route;
        @(posedge pclk) disable iff (!presetn || !por_n)
        (presetn && pin_sel_reg[5] == 6'h05) |=>
            pin_out[5] == $past(periph_out[4]);
    endproperty
    a_periph_route: assert property (p_periph_route)
        else $error("Pin not driven from chosen output");

    property p_upper_zero;
        @(posedge pclk) disable iff (!presetn || !por_n)
        (psel && !penable && in_hit) |=> prdata[31:SEL_W] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("Input selector upper bits nonzero");

    property p_in_route;
        @(posedge pclk) disable iff (!presetn || !por_n)
        ($past(presetn) && presetn && in_sel_reg[1] == 6'h0F) ##1
            (in_sel_reg[1] == 6'h0F) |=>
            periph_in[1] == $past(pin_in[15], 3);
    endproperty
    a_in_route: assert property (p_in_route)
        else $error("Input routed from wrong pin");

    property p_unlock;
        @(posedge pclk) disable iff (!presetn || !por_n)
        $changed(route_lock_flag_reg) |-> $past(lk_state_reg) == pprs_lk_armed;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("Lock changed without key pair");

    property p_keep;
        @(posedge pclk) disable iff (!por_n)
        $fell(presetn) |-> $stable(pin_sel_reg[2]);
    endproperty
    a_keep: assert property (p_keep)
        else $error("Selector lost on plain reset");
endmodule
